// ===== adcpc_params.svh
// timing, field and reset constants of the converter control port
`ifndef ADCPC_PARAMS_SVH
`define ADCPC_PARAMS_SVH

// ****************************************************************
// control word fields
// ****************************************************************
`define ADCPC_PWR_HI_BIT 3'h7
`define ADCPC_PWR_LO_BIT 3'h6
`define ADCPC_ACQ_BIT 3'h5
`define ADCPC_SGL_BIT 3'h4
`define ADCPC_UNI_BIT 3'h3
`define ADCPC_ADDR_MSB 2
`define ADCPC_ADDR_LSB 0
`define ADCPC_CTRL_RST 8'hc8

// ****************************************************************
// result layout
// ****************************************************************
`define ADCPC_RES_MSB 4'h9
`define ADCPC_DAC_START 10'h200
`define ADCPC_HB_PAD 6
`define ADCPC_HB_ZERO 6'h00

// ****************************************************************
// timing
// ****************************************************************
`define ADCPC_CLK_PERIOD_NS 13'h0064
`define ADCPC_INT_CONV_NS 13'h0e10
`define ADCPC_CONV_CYCLES 13'h000d
`define ADCPC_ACC_INC (`ADCPC_CONV_CYCLES * `ADCPC_CLK_PERIOD_NS)
`define ADCPC_LAST_STEP 4'hc
`define ADCPC_ACQ_LAST 2'h2

`endif

// ===== adcpc_pkg.sv
// types shared by the converter control port
package adcpc_pkg;

    // ************************************************************
    // sequencer states, one-hot
    // ************************************************************
    typedef enum logic [3:0] {
        ADCPC_ST_IDLE = 4'h1,
        ADCPC_ST_ACQ_INT = 4'h2,
        ADCPC_ST_ACQ_EXT = 4'h4,
        ADCPC_ST_CONV = 4'h8
    } adcpc_state_t;

    // ************************************************************
    // power modes
    // ************************************************************
    typedef enum logic [1:0] {
        ADCPC_PWR_SHUTDOWN = 2'h0,
        ADCPC_PWR_STANDBY = 2'h1,
        ADCPC_PWR_NORMAL = 2'h2
    } adcpc_pwr_t;

endpackage : adcpc_pkg

// ===== adcpc_chan_dec.sv
// analog input multiplexer channel decoder
`timescale 1ns/1ps
module adcpc_chan_dec #(
    parameter int NUM_CH = 8
) (
    input wire logic [2:0] i_addr,
    input wire logic i_single,
    output logic [NUM_CH-1:0] o_pos_sel,
    output logic [NUM_CH-1:0] o_neg_sel,
    output logic o_neg_common
);
    logic [2:0] idx;
    logic [NUM_CH-1:0] one;

    // ************************************************************
    // decode
    // ************************************************************
    always_comb begin
        one = {{(NUM_CH-1){1'b0}}, 1'b1};
        idx = i_addr & 3'(NUM_CH - 1);
        o_pos_sel = one << idx;
        o_neg_common = i_single;
        if (i_single) begin
            o_neg_sel = '0;
        end else begin
            o_neg_sel = one << (idx ^ 3'h1);
        end
    end

endmodule : adcpc_chan_dec

// ===== adcpc_port.sv
// control word capture, sequencing and byte readout of the converter
//
// Overview of operation
// - top bits 10 pick internal clock, 11 pick external clock.
// - power-down codes keep the last chosen clock source.
// - external clock source is selected after reset.
// - code 00 gives full shutdown, 01 standby; clock unchanged.
// - bit 5 low times acquisition internally, high waits second write.
// - acquisition bit and clock bits decode independently.
// - bit 4 high single-ended, low pseudo-differential pairs.
// - bit 3 high unipolar binary, low bipolar two's complement.
// - single-ended: address picks positive channel, common pin negative.
// - differential: upper address bits pick pair, low bit picks polarity.
// - four-channel build decodes only channels 0 to 3.
// - internal clock runs one conversion in 3.6 us.
// - chip select high ignores clock, write, read; bus high impedance.
// - write captures the 8-bit control word from the data bus.
// - high byte enable low drives result bits 0 to 7.
// - high byte enable high drives bits 8, 9 and zero or sign fill.
// - a conversion takes 13 conversion clock cycles.
// - internal acquisition ends after three clocks following the write.
// - a write during conversion aborts it and starts acquisition.
// - end flag low at result, high on read start or new write.
`timescale 1ns/1ps
`include "adcpc_params.svh"
module adcpc_port #(
    parameter int NUM_CH = 8
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_cs_n,
    input wire logic i_wr_n,
    input wire logic i_rd_n,
    input wire logic i_high_byte_enable,
    input wire logic [7:0] i_data,
    input wire logic i_conv_clk,
    input wire logic i_comparator,
    output logic [7:0] o_data,
    output logic o_data_oe_n,
    output logic o_eoc_n,
    output logic [9:0] o_dac_code,
    output logic o_track,
    output logic o_shutdown,
    output logic o_standby,
    output logic o_ext_clk_sel,
    output logic o_single_ended,
    output logic [NUM_CH-1:0] o_pos_sel,
    output logic [NUM_CH-1:0] o_neg_sel,
    output logic o_neg_common
);
    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        adcpc_pkg::adcpc_state_t state;
        adcpc_pkg::adcpc_pwr_t pwr;
        logic ext_sel;
        logic [7:0] ctrl;
        logic [7:0] wr_data;
        logic wr_act;
        logic rd_act;
        logic cclk_prev;
        logic [12:0] acc;
        logic [1:0] acq_cnt;
        logic [3:0] step;
        logic [9:0] dac;
        logic [9:0] result;
        logic bipolar;
        logic eoc_n;
        logic [7:0] dout;
        logic dout_oe_n;
        logic track;
        logic shutdown;
        logic standby;
        logic [NUM_CH-1:0] pos_sel;
        logic [NUM_CH-1:0] neg_sel;
        logic neg_common;
    } adcpc_port_st_t;

    adcpc_port_st_t q_reg;
    adcpc_port_st_t q_next;

    logic wr_now;
    logic rd_now;
    logic commit;
    logic tick;
    logic [12:0] acc_sum;
    logic [3:0] bidx;
    logic [NUM_CH-1:0] dec_pos;
    logic [NUM_CH-1:0] dec_neg;
    logic dec_common;

    // ************************************************************
    // channel decode of the word being written
    // ************************************************************
    adcpc_chan_dec #(
        .NUM_CH(NUM_CH)
    ) u_dec (
        .i_addr(q_reg.wr_data[`ADCPC_ADDR_MSB:`ADCPC_ADDR_LSB]),
        .i_single(q_reg.wr_data[`ADCPC_SGL_BIT]),
        .o_pos_sel(dec_pos),
        .o_neg_sel(dec_neg),
        .o_neg_common(dec_common)
    );

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        q_next = q_reg;
        wr_now = !i_cs_n && !i_wr_n;
        rd_now = !i_cs_n && !i_rd_n;
        commit = q_reg.wr_act && !wr_now;
        bidx = `ADCPC_RES_MSB - q_reg.step;
        acc_sum = q_reg.acc + `ADCPC_ACC_INC;
        tick = 1'b0;

        // conversion clock source
        q_next.cclk_prev = i_conv_clk;
        if (q_reg.state == adcpc_pkg::ADCPC_ST_IDLE ||
            q_reg.state == adcpc_pkg::ADCPC_ST_ACQ_EXT) begin
            q_next.acc = '0;
        end else if (q_reg.ext_sel) begin
            tick = i_conv_clk && !q_reg.cclk_prev && !i_cs_n;
            q_next.acc = '0;
        end else if (acc_sum >= `ADCPC_INT_CONV_NS) begin
            tick = 1'b1;
            q_next.acc = acc_sum - `ADCPC_INT_CONV_NS;
        end else begin
            q_next.acc = acc_sum;
        end

        // write strobe, data follows the bus while strobe is low
        q_next.wr_act = wr_now;
        if (wr_now) begin
            q_next.wr_data = i_data;
        end

        // read strobe and byte select
        q_next.rd_act = rd_now;
        q_next.dout_oe_n = !rd_now;
        if (i_high_byte_enable) begin
            q_next.dout = {q_reg.bipolar ?
                {`ADCPC_HB_PAD{q_reg.result[9]}} :
                `ADCPC_HB_ZERO, q_reg.result[9:8]};
        end else begin
            q_next.dout = q_reg.result[7:0];
        end
        if (rd_now && !q_reg.rd_act) begin
            q_next.eoc_n = 1'b1;
        end

        // sequencer
        case (q_reg.state)
            adcpc_pkg::ADCPC_ST_IDLE: begin
                q_next.track = 1'b0;
            end
            adcpc_pkg::ADCPC_ST_ACQ_INT: begin
                if (tick) begin
                    if (q_reg.acq_cnt == `ADCPC_ACQ_LAST) begin
                        q_next.state = adcpc_pkg::ADCPC_ST_CONV;
                        q_next.track = 1'b0;
                        q_next.step = '0;
                        q_next.dac = `ADCPC_DAC_START;
                    end else begin
                        q_next.acq_cnt = q_reg.acq_cnt + 2'h1;
                    end
                end
            end
            adcpc_pkg::ADCPC_ST_ACQ_EXT: begin
                q_next.track = 1'b1;
            end
            adcpc_pkg::ADCPC_ST_CONV: begin
                if (tick) begin
                    q_next.step = q_reg.step + 4'h1;
                    if (q_reg.step <= `ADCPC_RES_MSB) begin
                        if (!i_comparator) begin
                            q_next.dac[bidx] = 1'b0;
                        end
                        if (q_reg.step != `ADCPC_RES_MSB) begin
                            q_next.dac[bidx - 4'h1] = 1'b1;
                        end
                    end
                    if (q_reg.step == `ADCPC_LAST_STEP) begin
                        q_next.state = adcpc_pkg::ADCPC_ST_IDLE;
                        q_next.bipolar = !q_reg.ctrl[`ADCPC_UNI_BIT];
                        q_next.result = q_reg.ctrl[`ADCPC_UNI_BIT] ?
                            q_reg.dac :
                            {~q_reg.dac[9], q_reg.dac[8:0]};
                        q_next.eoc_n = 1'b0;
                    end
                end
            end
            default: begin
                q_next.state = adcpc_pkg::ADCPC_ST_IDLE;
                q_next.track = 1'b0;
            end
        endcase

        // a finished write reconfigures and restarts
        if (commit) begin
            q_next.ctrl = q_reg.wr_data;
            q_next.eoc_n = 1'b1;
            q_next.acq_cnt = '0;
            q_next.acc = '0;
            q_next.pos_sel = dec_pos;
            q_next.neg_sel = dec_neg;
            q_next.neg_common = dec_common;
            if (q_reg.wr_data[`ADCPC_PWR_HI_BIT]) begin
                q_next.ext_sel = q_reg.wr_data[`ADCPC_PWR_LO_BIT];
                q_next.pwr = adcpc_pkg::ADCPC_PWR_NORMAL;
            end else if (q_reg.wr_data[`ADCPC_PWR_LO_BIT]) begin
                q_next.pwr = adcpc_pkg::ADCPC_PWR_STANDBY;
            end else begin
                q_next.pwr = adcpc_pkg::ADCPC_PWR_SHUTDOWN;
            end
            if (q_reg.wr_data[`ADCPC_ACQ_BIT]) begin
                q_next.state = adcpc_pkg::ADCPC_ST_ACQ_EXT;
                q_next.track = 1'b1;
            end else if (q_reg.state == adcpc_pkg::ADCPC_ST_ACQ_EXT) begin
                q_next.state = adcpc_pkg::ADCPC_ST_CONV;
                q_next.track = 1'b0;
                q_next.step = '0;
                q_next.dac = `ADCPC_DAC_START;
            end else begin
                q_next.state = adcpc_pkg::ADCPC_ST_ACQ_INT;
                q_next.track = 1'b1;
            end
        end

        // power state shows only while the converter rests
        q_next.shutdown = (q_next.pwr == adcpc_pkg::ADCPC_PWR_SHUTDOWN) &&
            (q_next.state == adcpc_pkg::ADCPC_ST_IDLE);
        q_next.standby = (q_next.pwr == adcpc_pkg::ADCPC_PWR_STANDBY) &&
            (q_next.state == adcpc_pkg::ADCPC_ST_IDLE);
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            q_reg <= '0;
            q_reg.state <= adcpc_pkg::ADCPC_ST_IDLE;
            q_reg.pwr <= adcpc_pkg::ADCPC_PWR_NORMAL;
            q_reg.ext_sel <= 1'b1;
            q_reg.ctrl <= `ADCPC_CTRL_RST;
            q_reg.bipolar <= 1'b0;
            q_reg.eoc_n <= 1'b1;
            q_reg.dout_oe_n <= 1'b1;
        end else begin
            q_reg <= q_next;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign o_data = q_reg.dout;
    assign o_data_oe_n = q_reg.dout_oe_n;
    assign o_eoc_n = q_reg.eoc_n;
    assign o_dac_code = q_reg.dac;
    assign o_track = q_reg.track;
    assign o_shutdown = q_reg.shutdown;
    assign o_standby = q_reg.standby;
    assign o_ext_clk_sel = q_reg.ext_sel;
    assign o_single_ended = q_reg.neg_common;
    assign o_pos_sel = q_reg.pos_sel;
    assign o_neg_sel = q_reg.neg_sel;
    assign o_neg_common = q_reg.neg_common;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_nrst);

    sequence s_commit_word;
        commit && q_reg.wr_data[`ADCPC_PWR_HI_BIT];
    endsequence

    sequence s_last_step;
        q_reg.state == adcpc_pkg::ADCPC_ST_CONV && tick &&
            q_reg.step == `ADCPC_LAST_STEP && !commit;
    endsequence

    property p_reset_ext;
        $rose(i_nrst) |-> o_ext_clk_sel;
    endproperty
    a_reset_ext: assert property (p_reset_ext)
        else $error("external clock not selected after reset");

    property p_clk_sel;
        s_commit_word |=>
            o_ext_clk_sel == $past(q_reg.wr_data[`ADCPC_PWR_LO_BIT]);
    endproperty
    a_clk_sel: assert property (p_clk_sel)
        else $error("clock source not taken from control word");

    property p_clk_keep;
        commit && !q_reg.wr_data[`ADCPC_PWR_HI_BIT] |=>
            $stable(o_ext_clk_sel);
    endproperty
    a_clk_keep: assert property (p_clk_keep)
        else $error("power-down word changed clock source");

    property p_shutdown;
        commit && !q_reg.wr_data[`ADCPC_PWR_HI_BIT] &&
            !q_reg.wr_data[`ADCPC_PWR_LO_BIT] |=>
            q_reg.pwr == adcpc_pkg::ADCPC_PWR_SHUTDOWN;
    endproperty
    a_shutdown: assert property (p_shutdown)
        else $error("code 00 did not select shutdown");

    property p_hiz;
        i_cs_n |=> o_data_oe_n;
    endproperty
    a_hiz: assert property (p_hiz)
        else $error("bus driven while chip select high");

    property p_low_byte;
        !i_cs_n && !i_rd_n && !i_high_byte_enable |=>
            !o_data_oe_n && o_data == $past(q_reg.result[7:0]);
    endproperty
    a_low_byte: assert property (p_low_byte)
        else $error("low byte wrong");

    property p_high_byte;
        !i_cs_n && !i_rd_n && i_high_byte_enable |=>
            o_data[1:0] == $past(q_reg.result[9:8]) &&
            o_data[7:2] == ($past(q_reg.bipolar) ?
                {6{$past(q_reg.result[9])}} : 6'h00);
    endproperty
    a_high_byte: assert property (p_high_byte)
        else $error("high byte wrong");

    property p_abort;
        commit && (q_reg.wr_data[`ADCPC_ACQ_BIT] ||
            q_reg.state != adcpc_pkg::ADCPC_ST_ACQ_EXT) |=>
            o_eoc_n && o_track;
    endproperty
    a_abort: assert property (p_abort)
        else $error("write did not restart acquisition");

    property p_ext_start;
        commit && !q_reg.wr_data[`ADCPC_ACQ_BIT] &&
            q_reg.state == adcpc_pkg::ADCPC_ST_ACQ_EXT |=>
            o_eoc_n && !o_track &&
            q_reg.state == adcpc_pkg::ADCPC_ST_CONV;
    endproperty
    a_ext_start: assert property (p_ext_start)
        else $error("second write did not start conversion");

    property p_acq_three;
        q_reg.state == adcpc_pkg::ADCPC_ST_ACQ_INT && tick &&
            q_reg.acq_cnt == `ADCPC_ACQ_LAST && !commit |=>
            q_reg.state == adcpc_pkg::ADCPC_ST_CONV && !o_track;
    endproperty
    a_acq_three: assert property (p_acq_three)
        else $error("acquisition did not end after three clocks");

    property p_conv_done;
        s_last_step |=> !o_eoc_n &&
            q_reg.state == adcpc_pkg::ADCPC_ST_IDLE;
    endproperty
    a_conv_done: assert property (p_conv_done)
        else $error("end flag not low after last conversion step");

    property p_eoc_read;
        !o_eoc_n && !i_cs_n && !i_rd_n && !q_reg.rd_act &&
            !(q_reg.state == adcpc_pkg::ADCPC_ST_CONV && tick) |=> o_eoc_n;
    endproperty
    a_eoc_read: assert property (p_eoc_read)
        else $error("end flag not released by read");

    property p_mux;
        commit |=> o_pos_sel == $past(dec_pos) &&
            o_neg_common == $past(q_reg.wr_data[`ADCPC_SGL_BIT]);
    endproperty
    a_mux: assert property (p_mux)
        else $error("multiplexer not set from control word");

endmodule : adcpc_port

// ===== adcpc_host_model.sv
// host side model: external conversion clock and comparator
`timescale 1ns/1ps
module adcpc_host_model (
    input wire logic i_clk,
    input wire logic i_run,
    input wire logic [9:0] i_level,
    input wire logic [9:0] i_dac_code,
    output logic o_conv_clk,
    output logic o_comparator
);
    logic [2:0] div_reg;

    // ************************************************************
    // 1 mhz clock, half duty, still while not running
    // ************************************************************
    always_ff @(posedge i_clk) begin
        if (!i_run) begin
            div_reg <= 3'h0;
            o_conv_clk <= 1'b0;
        end else if (div_reg == 3'h4) begin
            div_reg <= 3'h0;
            o_conv_clk <= ~o_conv_clk;
        end else begin
            div_reg <= div_reg + 3'h1;
        end
    end

    // ************************************************************
    // comparator: keep bit while input at or above trial
    // ************************************************************
    assign o_comparator = (i_level >= i_dac_code);
endmodule : adcpc_host_model

// ===== testbench.sv
// self-checking bench of the converter control port
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic cs_n = 1'b1;
    logic wr_n = 1'b1;
    logic rd_n = 1'b1;
    logic high_byte_enable = 1'b0;
    logic [7:0] data = 8'h00;
    logic run = 1'b0;
    logic [9:0] level = 10'h000;
    logic conv_clk, comp, oe_n, eoc_n, track, shut, stby, ext, sgl, common_return_input;
    logic [7:0] dout, pos, neg;
    logic [9:0] dac;
    int fails = 0;
    int n_compared = 0;
    int n;

    always #50 clk = ~clk;

    adcpc_port #(.NUM_CH(8)) uut (
        .i_clk(clk), .i_nrst(nrst), .i_cs_n(cs_n), .i_wr_n(wr_n),
        .i_rd_n(rd_n), .i_high_byte_enable(high_byte_enable), .i_data(data),
        .i_conv_clk(conv_clk), .i_comparator(comp), .o_data(dout),
        .o_data_oe_n(oe_n), .o_eoc_n(eoc_n), .o_dac_code(dac),
        .o_track(track), .o_shutdown(shut), .o_standby(stby),
        .o_ext_clk_sel(ext), .o_single_ended(sgl), .o_pos_sel(pos),
        .o_neg_sel(neg), .o_neg_common(common_return_input)
    );

    adcpc_host_model host (
        .i_clk(clk), .i_run(run), .i_level(level), .i_dac_code(dac),
        .o_conv_clk(conv_clk), .o_comparator(comp)
    );

    // ************************************************************
    // compare and bus tasks
    // ************************************************************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic chk_span(input int lo, input int hi);
        n_compared++;
        if (n < lo || n > hi) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, n, lo);
        end
    endtask : chk_span

    task automatic wr(input logic [7:0] w);
        @(posedge clk);
        #1;
        cs_n = 1'b0;
        wr_n = 1'b0;
        data = w;
        @(posedge clk);
        #1;
        wr_n = 1'b1;
        repeat (2) @(posedge clk);
        #1;
    endtask : wr

    task automatic rd(input logic h, input logic [7:0] exp);
        @(posedge clk);
        #1;
        rd_n = 1'b0;
        high_byte_enable = h;
        repeat (2) @(posedge clk);
        #1;
        chk({15'h0000, oe_n}, 16'h0000);
        chk({8'h00, dout}, {8'h00, exp});
        rd_n = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chk({15'h0000, oe_n}, 16'h0001);
    endtask : rd

    task automatic wait_eoc;
        n = 0;
        while (eoc_n !== 1'b0 && n < 400) begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask : wait_eoc

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_internal;
        level = 10'h3a5;
        wr(8'h9d);
        chk({15'h0000, ext}, 16'h0000);
        chk({15'h0000, track}, 16'h0001);
        chk({15'h0000, sgl}, 16'h0001);
        chk({8'h00, pos}, 16'h0020);
        chk({7'h00, neg, common_return_input}, 16'h0001);
        wait_eoc();
        chk_span(38, 52);
        rd(1'b0, 8'ha5);
        rd(1'b1, 8'h03);
        chk({15'h0000, eoc_n}, 16'h0001);
        $display("test internal done");
    endtask : t_internal

    task automatic t_external;
        level = 10'h0a5;
        run = 1'b1;
        wr(8'hc2);
        chk({15'h0000, ext}, 16'h0001);
        chk({15'h0000, sgl}, 16'h0000);
        chk({8'h00, pos}, 16'h0004);
        chk({7'h00, neg, common_return_input}, 16'h0010);
        wait_eoc();
        chk_span(150, 172);
        rd(1'b1, 8'hfe);
        rd(1'b0, 8'ha5);
        run = 1'b0;
        $display("test external done");
    endtask : t_external

    task automatic t_power;
        wr(8'h9d);
        repeat (60) @(posedge clk);
        wr(8'h1d);
        chk({15'h0000, ext}, 16'h0000);
        repeat (60) @(posedge clk);
        #1;
        chk({14'h0000, shut, stby}, 16'h0002);
        wr(8'h5d);
        chk({15'h0000, ext}, 16'h0000);
        repeat (60) @(posedge clk);
        #1;
        chk({14'h0000, shut, stby}, 16'h0001);
        $display("test power done");
    endtask : t_power

    task automatic t_ext_acq;
        wr(8'hbd);
        repeat (30) @(posedge clk);
        #1;
        chk({14'h0000, track, eoc_n}, 16'h0003);
        wr(8'h9d);
        chk({15'h0000, track}, 16'h0000);
        wait_eoc();
        chk_span(32, 42);
        $display("test external acquisition done");
    endtask : t_ext_acq

    task automatic t_abort;
        chk({15'h0000, eoc_n}, 16'h0000);
        wr(8'h9d);
        chk({15'h0000, eoc_n}, 16'h0001);
        repeat (20) @(posedge clk);
        wr(8'h9d);
        chk({15'h0000, track}, 16'h0001);
        wait_eoc();
        chk_span(38, 52);
        $display("test abort done");
    endtask : t_abort

    task automatic t_deselect;
        @(posedge clk);
        #1;
        cs_n = 1'b1;
        rd_n = 1'b0;
        wr_n = 1'b0;
        data = 8'hdd;
        repeat (3) @(posedge clk);
        #1;
        chk({15'h0000, oe_n}, 16'h0001);
        rd_n = 1'b1;
        wr_n = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk({15'h0000, ext}, 16'h0000);
        $display("test deselect done");
    endtask : t_deselect

    task automatic close_out;
        $display("compared %0d, failed %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : close_out

    // ************************************************************
    // main sequence and watchdog
    // ************************************************************
    initial begin
        repeat (2) @(posedge clk);
        #1;
        nrst = 1'b1;
        chk({13'h0000, ext, eoc_n, oe_n}, 16'h0007);
        t_internal();
        t_external();
        t_power();
        t_ext_acq();
        t_abort();
        t_deselect();
        close_out();
    end

    initial begin
        #300_000;
        fails++;
        close_out();
    end
endmodule : testbench
